// File: rtl/timer16_pkg.sv
package timer16_pkg;
  // --------------------------------------------------------------------
  // register map (byte addresses, one word each)
  // --------------------------------------------------------------------
  localparam logic [5:0] ADDR_CTRL_A = 6'h00;
  localparam logic [5:0] ADDR_CTRL_B = 6'h04;
  localparam logic [5:0] ADDR_COMPARE_A = 6'h08;
  localparam logic [5:0] ADDR_COMPARE_B = 6'h0C;
  localparam logic [5:0] ADDR_COMPARE_C = 6'h10;
  localparam logic [5:0] ADDR_CAPTURE = 6'h14;
  localparam logic [5:0] ADDR_COUNT = 6'h18;
  localparam logic [5:0] ADDR_STATUS = 6'h1C;
  localparam logic [5:0] ADDR_MASK = 6'h20;
  localparam logic [5:0] ADDR_DIR = 6'h24;
  localparam int ADDR_W = 6;
  // --------------------------------------------------------------------
  // field positions and reset values
  // --------------------------------------------------------------------
  localparam int CHAN_A_LSB = 6;
  localparam int CHAN_B_LSB = 4;
  localparam int CHAN_C_LSB = 2;
  localparam int NOISE_BIT = 7;
  localparam int EDGE_BIT = 6;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] VALUE_RESET = 16'h0000;
  localparam logic [31:0] BUS_ERR_DATA = 32'h0000_0000;
  // status bits: overflow, match a/b/c, capture
  localparam int ST_OVF = 0;
  localparam int ST_MA = 1;
  localparam int ST_CAP = 4;
  localparam int ST_W = 5;
  // --------------------------------------------------------------------
  // tops and prescale
  // --------------------------------------------------------------------
  localparam logic [15:0] TOP_MAX = 16'hFFFF;
  localparam logic [15:0] TOP_8 = 16'h00FF;
  localparam logic [15:0] TOP_9 = 16'h01FF;
  localparam logic [15:0] TOP_10 = 16'h03FF;
  localparam logic [15:0] BOTTOM = 16'h0000;
  localparam logic [9:0] DIV_8 = 10'h007;
  localparam logic [9:0] DIV_64 = 10'h03F;
  localparam logic [9:0] DIV_256 = 10'h0FF;
  localparam logic [9:0] DIV_1024 = 10'h3FF;
  localparam logic [1:0] FILTER_LEN = 2'h3;
  // waveform families
  typedef enum logic [3:0] {
    FAM_NORMAL = 4'h1,
    FAM_FAST = 4'h2,
    FAM_PHASE = 4'h4,
    FAM_PFC = 4'h8
  } family_t;
  // per-mode decode
  typedef struct packed {
    family_t fam;
    logic [15:0] top;
    logic reserved;
  } mode_t;
endpackage

// File: rtl/timer16_waveform_mode_control.sv
// Contract
// - nonzero action field hands pin to compare
// - pin driven only when direction bit set
// - non-PWM: off, toggle, clear, set on match
// - fast PWM: 10 clear/set-top, 11 inverse
// - PWM 01: toggle A only when mode bit3
// - fast PWM compare equal top: top action only
// - dual slope: 10 clear up, set down
// - mode low bits ctrl_a, high bits ctrl_b
// - normal/clear-on-match tops, immediate, overflow at max
// - fixed tops 8, 9, 10 bit
// - variable tops from capture or compare A
// - buffer load and overflow point per family
// - clock source stop, prescale, external edges
// - capture edge select falling or rising
// - noise filter four equal samples
// - dual slope extremes hold output constant
module timer16_waveform_mode_control (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // pins
  input wire logic extClockPin,
  input wire logic capturePin,
  output logic [2:0] compareOut,
  output logic [2:0] pinOverride,
  output logic [2:0] pinOutEnable,
  // interrupt
  output logic irq
);
  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  localparam int ST_W = timer16_pkg::ST_W;
  logic [7:0] ctrlA; // action fields and mode low bits
  logic [7:0] ctrlB; // filter, edge, mode high bits, clock
  logic [15:0] cmpBuf [3]; // software-written compare values
  logic [15:0] cmpAct [3]; // values in use by the comparators
  logic [15:0] captureValue;
  logic [15:0] countValue;
  logic [2:0] portDir; // direction bits of the three pins
  logic [ST_W-1:0] status;
  logic [ST_W-1:0] mask;
  logic countDown;
  logic [2:0] ocState; // compare output flip-flops
  logic ackPend; // one wait cycle per access
  logic [9:0] prescale;
  logic extSync1, extSync2, extPrev;
  logic capSync1, capSync2, capFilt, capPrev;
  logic [1:0] capCnt;

  // --------------------------------------------------------------------
  // mode decode
  // --------------------------------------------------------------------
  logic [3:0] waveGenSelect;
  timer16_pkg::mode_t modeInfo;
  logic [2:0] clockSourceSelect;
  assign waveGenSelect = {ctrlB[4:3], ctrlA[1:0]};
  assign clockSourceSelect = ctrlB[2:0];

  // top source and family per mode
  always_comb begin
    modeInfo.reserved = 1'b0;
    modeInfo.fam = timer16_pkg::FAM_NORMAL;
    modeInfo.top = timer16_pkg::TOP_MAX;
    case (waveGenSelect)
      4'h0: modeInfo.top = timer16_pkg::TOP_MAX;
      4'h1: begin
        modeInfo.fam = timer16_pkg::FAM_PHASE;
        modeInfo.top = timer16_pkg::TOP_8;
      end
      4'h2: begin
        modeInfo.fam = timer16_pkg::FAM_PHASE;
        modeInfo.top = timer16_pkg::TOP_9;
      end
      4'h3: begin
        modeInfo.fam = timer16_pkg::FAM_PHASE;
        modeInfo.top = timer16_pkg::TOP_10;
      end
      4'h4: modeInfo.top = cmpAct[0];
      4'h5: begin
        modeInfo.fam = timer16_pkg::FAM_FAST;
        modeInfo.top = timer16_pkg::TOP_8;
      end
      4'h6: begin
        modeInfo.fam = timer16_pkg::FAM_FAST;
        modeInfo.top = timer16_pkg::TOP_9;
      end
      4'h7: begin
        modeInfo.fam = timer16_pkg::FAM_FAST;
        modeInfo.top = timer16_pkg::TOP_10;
      end
      4'h8: begin
        modeInfo.fam = timer16_pkg::FAM_PFC;
        modeInfo.top = captureValue;
      end
      4'h9: begin
        modeInfo.fam = timer16_pkg::FAM_PFC;
        modeInfo.top = cmpAct[0];
      end
      4'hA: begin
        modeInfo.fam = timer16_pkg::FAM_PHASE;
        modeInfo.top = captureValue;
      end
      4'hB: begin
        modeInfo.fam = timer16_pkg::FAM_PHASE;
        modeInfo.top = cmpAct[0];
      end
      4'hC: modeInfo.top = captureValue;
      4'hD: modeInfo.reserved = 1'b1;
      4'hE: begin
        modeInfo.fam = timer16_pkg::FAM_FAST;
        modeInfo.top = captureValue;
      end
      default: begin
        modeInfo.fam = timer16_pkg::FAM_FAST;
        modeInfo.top = cmpAct[0];
      end
    endcase
  end

  // --------------------------------------------------------------------
  // clock source
  // --------------------------------------------------------------------
  // external pin: two-flop sync, edge taken from second stage only
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      extSync1 <= 1'b0;
      extSync2 <= 1'b0;
      extPrev <= 1'b0;
    end else begin
      extSync1 <= extClockPin;
      extSync2 <= extSync1;
      extPrev <= extSync2;
    end
  end

  // free-running prescaler; the tick is a clock enable, not a clock
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prescale <= 10'h000;
    end else begin
      prescale <= prescale + 10'h001;
    end
  end

  logic tick;
  always_comb begin
    case (clockSourceSelect)
      3'h0: tick = 1'b0;
      3'h1: tick = 1'b1;
      3'h2: tick = (prescale[2:0] == timer16_pkg::DIV_8[2:0]);
      3'h3: tick = (prescale[5:0] == timer16_pkg::DIV_64[5:0]);
      3'h4: tick = (prescale[7:0] == timer16_pkg::DIV_256[7:0]);
      3'h5: tick = (prescale == timer16_pkg::DIV_1024);
      3'h6: tick = extPrev & ~extSync2;
      default: tick = ~extPrev & extSync2;
    endcase
  end

  // --------------------------------------------------------------------
  // counter and buffered compare values
  // --------------------------------------------------------------------
  logic atTop, atBottom, isPwm, isFast, isDual;
  logic loadNow, ovfNow;
  logic [2:0] match;
  assign atTop = (countValue == modeInfo.top);
  assign atBottom = (countValue == timer16_pkg::BOTTOM);
  assign isFast = (modeInfo.fam == timer16_pkg::FAM_FAST);
  assign isDual = (modeInfo.fam == timer16_pkg::FAM_PHASE) |
                  (modeInfo.fam == timer16_pkg::FAM_PFC);
  assign isPwm = isFast | isDual;

  // load and overflow points per family
  always_comb begin
    case (modeInfo.fam)
      timer16_pkg::FAM_FAST: begin
        loadNow = atTop;
        ovfNow = atTop;
      end
      timer16_pkg::FAM_PHASE: begin
        loadNow = atTop;
        ovfNow = atBottom & countDown;
      end
      timer16_pkg::FAM_PFC: begin
        loadNow = atBottom & countDown;
        ovfNow = atBottom & countDown;
      end
      default: begin
        loadNow = 1'b1;
        ovfNow = (countValue == timer16_pkg::TOP_MAX);
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      countValue <= timer16_pkg::VALUE_RESET;
      countDown <= 1'b0;
    end else if (write && ackPend && address == timer16_pkg::ADDR_COUNT) begin
      countValue <= writedata[15:0];
    end else if (tick && !modeInfo.reserved) begin
      if (isDual) begin
        if (atTop) begin
          countDown <= 1'b1;
          countValue <= countValue - 16'h0001;
        end else if (atBottom && countDown) begin
          countDown <= 1'b0;
          countValue <= countValue + 16'h0001;
        end else if (countDown) begin
          countValue <= countValue - 16'h0001;
        end else begin
          countValue <= countValue + 16'h0001;
        end
      end else begin
        countDown <= 1'b0;
        countValue <= atTop ? timer16_pkg::BOTTOM : countValue + 16'h0001;
      end
    end
  end

  // buffer to active transfer
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 3; i++) cmpAct[i] <= timer16_pkg::VALUE_RESET;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (!isPwm || (tick && loadNow)) cmpAct[i] <= cmpBuf[i];
      end
    end
  end

  // --------------------------------------------------------------------
  // capture input
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      capSync1 <= 1'b1;
      capSync2 <= 1'b1;
      capFilt <= 1'b1;
      capPrev <= 1'b1;
      capCnt <= 2'h0;
    end else begin
      capSync1 <= capturePin;
      capSync2 <= capSync1;
      capPrev <= capFilt;
      if (!ctrlB[timer16_pkg::NOISE_BIT]) begin
        capFilt <= capSync2;
        capCnt <= 2'h0;
      end else if (capSync2 == capFilt) begin
        capCnt <= 2'h0;
      end else if (capCnt == timer16_pkg::FILTER_LEN) begin
        capFilt <= capSync2;
        capCnt <= 2'h0;
      end else begin
        capCnt <= capCnt + 2'h1;
      end
    end
  end

  logic capEvent;
  logic capAsTop;
  assign capAsTop = (waveGenSelect == 4'h8) | (waveGenSelect == 4'hA) |
                    (waveGenSelect == 4'hC) | (waveGenSelect == 4'hE);
  assign capEvent = !capAsTop && (ctrlB[timer16_pkg::EDGE_BIT] ?
                    (capFilt & ~capPrev) : (~capFilt & capPrev));

  // --------------------------------------------------------------------
  // compare outputs
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ocState <= 3'h0;
    end else if (tick) begin
      for (int i = 0; i < 3; i++) begin
        logic [1:0] act;
        logic hit;
        act = ctrlA[7-2*i -: 2];
        hit = (countValue == cmpAct[i]);
        if (!isPwm) begin
          if (hit) begin
            case (act)
              2'h1: ocState[i] <= ~ocState[i];
              2'h2: ocState[i] <= 1'b0;
              2'h3: ocState[i] <= 1'b1;
              default: ocState[i] <= ocState[i];
            endcase
          end
        end else if (act == 2'h1) begin
          if (i == 0 && waveGenSelect[3] && hit) ocState[i] <= ~ocState[i];
        end else if (act[1] && isFast) begin
          if (atTop) ocState[i] <= ~act[0];
          else if (hit) ocState[i] <= act[0];
        end else if (act[1] && isDual) begin
          if (cmpAct[i] == timer16_pkg::BOTTOM) ocState[i] <= act[0];
          else if (cmpAct[i] == modeInfo.top) ocState[i] <= ~act[0];
          else if (hit) ocState[i] <= countDown ? ~act[0] : act[0];
        end
      end
    end
  end

  // override and driver enable per pin
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pinOverride[i] = (ctrlA[7-2*i -: 2] != 2'h0);
      pinOutEnable[i] = pinOverride[i] & portDir[i];
    end
  end
  assign compareOut = ocState;

  // --------------------------------------------------------------------
  // events and interrupt
  // --------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 3; i++) match[i] = tick && (countValue == cmpAct[i]);
  end

  logic [ST_W-1:0] evt;
  assign evt = {capEvent, match, tick & ovfNow};

  // a read clears only the bits it returned, so no event is lost; set wins
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      status <= '0;
    end else if (read && ackPend && address == timer16_pkg::ADDR_STATUS) begin
      status <= (status & ~readdata[ST_W-1:0]) | evt;
    end else begin
      status <= status | evt;
    end
  end
  assign irq = |(status & mask);

  // --------------------------------------------------------------------
  // avalon-mm slave: one wait cycle, answer on the second edge
  // --------------------------------------------------------------------
  assign waitrequest = (read | write) & ~ackPend;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) ackPend <= 1'b0;
    else ackPend <= (read | write) & ~ackPend;
  end

  // register writes; reserved bit 5 of ctrl_b stays zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrlA <= timer16_pkg::CTRL_RESET;
      ctrlB <= timer16_pkg::CTRL_RESET;
      for (int i = 0; i < 3; i++) cmpBuf[i] <= timer16_pkg::VALUE_RESET;
      mask <= '0;
      portDir <= 3'h0;
    end else if (write && ackPend) begin
      case (address)
        timer16_pkg::ADDR_CTRL_A: ctrlA <= writedata[7:0];
        timer16_pkg::ADDR_CTRL_B: ctrlB <= writedata[7:0] & 8'hDF;
        timer16_pkg::ADDR_COMPARE_A: cmpBuf[0] <= writedata[15:0];
        timer16_pkg::ADDR_COMPARE_B: cmpBuf[1] <= writedata[15:0];
        timer16_pkg::ADDR_COMPARE_C: cmpBuf[2] <= writedata[15:0];
        timer16_pkg::ADDR_MASK: mask <= writedata[ST_W-1:0];
        timer16_pkg::ADDR_DIR: portDir <= writedata[2:0];
        default: mask <= mask; // unmapped writes ignored
      endcase
    end
  end

  // capture register: software write or capture event
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) captureValue <= timer16_pkg::VALUE_RESET;
    else if (capEvent) captureValue <= countValue;
    else if (write && ackPend && address == timer16_pkg::ADDR_CAPTURE)
      captureValue <= writedata[15:0];
  end

  // read data registered at the accept edge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      readdata <= timer16_pkg::BUS_ERR_DATA;
    end else if (read && !ackPend) begin
      case (address)
        timer16_pkg::ADDR_CTRL_A: readdata <= {24'h0, ctrlA};
        timer16_pkg::ADDR_CTRL_B: readdata <= {24'h0, ctrlB};
        timer16_pkg::ADDR_COMPARE_A: readdata <= {16'h0, cmpBuf[0]};
        timer16_pkg::ADDR_COMPARE_B: readdata <= {16'h0, cmpBuf[1]};
        timer16_pkg::ADDR_COMPARE_C: readdata <= {16'h0, cmpBuf[2]};
        timer16_pkg::ADDR_CAPTURE: readdata <= {16'h0, captureValue};
        timer16_pkg::ADDR_COUNT: readdata <= {16'h0, countValue};
        timer16_pkg::ADDR_STATUS: readdata <= {27'h0, status};
        timer16_pkg::ADDR_MASK: readdata <= {27'h0, mask};
        timer16_pkg::ADDR_DIR: readdata <= {29'h0, portDir};
        default: readdata <= timer16_pkg::BUS_ERR_DATA;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  property p_override;
    @(posedge clk_sys) disable iff (!rst_n)
      (ctrlA[7:6] != 2'h0) |-> pinOverride[0];
  endproperty
  a_override: assert property (p_override) else $error("override missing");

  property p_enable;
    @(posedge clk_sys) disable iff (!rst_n)
      pinOutEnable[1] |-> (portDir[1] && ctrlA[5:4] != 2'h0);
  endproperty
  a_enable: assert property (p_enable) else $error("driver without direction");

  property p_nonpwm_clear;
    @(posedge clk_sys) disable iff (!rst_n)
      (tick && !isPwm && ctrlA[3:2] == 2'h2 && countValue == cmpAct[2]) |=> !ocState[2];
  endproperty
  a_nonpwm_clear: assert property (p_nonpwm_clear) else $error("clear on match");

  property p_fast_top;
    @(posedge clk_sys) disable iff (!rst_n)
      (tick && isFast && atTop && ctrlA[5:4] == 2'h2) |=> ocState[1];
  endproperty
  a_fast_top: assert property (p_fast_top) else $error("fast top set");

  property p_stopped;
    @(posedge clk_sys) disable iff (!rst_n)
      (clockSourceSelect == 3'h0 && !write) |=> $stable(countValue);
  endproperty
  a_stopped: assert property (p_stopped) else $error("counter moved while stopped");

  property p_mode_top;
    @(posedge clk_sys) disable iff (!rst_n)
      (waveGenSelect == 4'h5) |-> (modeInfo.top == timer16_pkg::TOP_8);
  endproperty
  a_mode_top: assert property (p_mode_top) else $error("mode 5 top");

  sequence s_access;
    waitrequest ##1 (!waitrequest || !(read || write));
  endsequence
  property p_bus;
    @(posedge clk_sys) disable iff (!rst_n)
      (read || write) && !ackPend |-> s_access;
  endproperty
  a_bus: assert property (p_bus) else $error("bus answer late");

  property p_irq;
    @(posedge clk_sys) disable iff (!rst_n)
      (tick && ovfNow && mask[timer16_pkg::ST_OVF] &&
       !(write && address == timer16_pkg::ADDR_MASK)) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("overflow irq missing");
endmodule

// File: test/port_pin_model.sv
// ----------------------------------------------------------------------
// port pad model: ordinary port level unless the compare unit owns the pin
// ----------------------------------------------------------------------
module port_pin_model (
  // design side
  input wire logic [2:0] compareOut,
  input wire logic [2:0] pinOverride,
  input wire logic [2:0] pinOutEnable,
  // ordinary port function
  input wire logic [2:0] portLevel,
  // pads
  output logic [2:0] padLevel
);
  timeunit 1ns;
  timeprecision 1ps;
  // pad resolution, one pin at a time
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (pinOutEnable[i]) begin
        padLevel[i] = compareOut[i];
      end else if (pinOverride[i]) begin
        // port released but driver off: pad floats to its pull-up
        padLevel[i] = 1'b1;
      end else begin
        padLevel[i] = portLevel[i];
      end
    end
  end
endmodule

// File: test/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------------
  // signals
  // --------------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] address = 6'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [31:0] readdata;
  logic waitrequest;
  logic extClockPin = 1'b0;
  logic capturePin = 1'b1;
  logic [2:0] compareOut;
  logic [2:0] pinOverride;
  logic [2:0] pinOutEnable;
  logic [2:0] padLevel;
  logic irq;
  logic [31:0] rd; // last read data
  int error_cnt = 0;
  int cmp_count = 0;
  int cycles = 0;
  int hi; // high samples in a window
  int tg; // level changes in a window
  // free-running clock, 25 ns period
  always #12.5 clk_sys = ~clk_sys;
  timer16_waveform_mode_control dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .extClockPin(extClockPin),
    .capturePin(capturePin), .compareOut(compareOut),
    .pinOverride(pinOverride), .pinOutEnable(pinOutEnable), .irq(irq));
  port_pin_model pads (
    .compareOut(compareOut), .pinOverride(pinOverride),
    .pinOutEnable(pinOutEnable), .portLevel(3'h0), .padLevel(padLevel));
  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // hang guard, well above the roughly 9k cycles the tests need
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      error_cnt++;
      end_sim();
    end
  end
  // one avalon cycle; waitrequest and read data taken at the rising edge
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= ~wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (waitrequest !== 1'b0);
    chk("bus wait", n, 32'h2);
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask
  // stop, rewind, then program control a and b
  task automatic cfg(input logic [7:0] a, input logic [7:0] b);
    bus(1'b1, timer16_pkg::ADDR_CTRL_B, 32'h0);
    bus(1'b1, timer16_pkg::ADDR_COUNT, 32'h0);
    bus(1'b1, timer16_pkg::ADDR_CTRL_A, {24'h0, a});
    bus(1'b1, timer16_pkg::ADDR_CTRL_B, {24'h0, b});
  endtask
  task automatic measure(input int ch, input int len);
    logic p;
    hi = 0;
    tg = 0;
    p = compareOut[ch];
    repeat (len) begin
      @(negedge clk_sys);
      hi += (compareOut[ch] === 1'b1);
      tg += (compareOut[ch] !== p);
      p = compareOut[ch];
    end
  endtask
  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  task automatic t_reset();
    bus(1'b0, timer16_pkg::ADDR_CTRL_A, 32'h0);
    chk("ctrl_a reset", rd, 32'h0);
    bus(1'b0, timer16_pkg::ADDR_CTRL_B, 32'h0);
    chk("ctrl_b reset", rd, 32'h0);
    chk("override reset", {29'h0, pinOverride}, 32'h0);
    repeat (20) @(posedge clk_sys);
    bus(1'b0, timer16_pkg::ADDR_COUNT, 32'h0);
    chk("stopped count", rd, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_regs();
    bus(1'b1, timer16_pkg::ADDR_CTRL_A, 32'h0000_00FF);
    bus(1'b0, timer16_pkg::ADDR_CTRL_A, 32'h0);
    chk("ctrl_a rw", rd, 32'h0000_00FF);
    bus(1'b1, timer16_pkg::ADDR_CTRL_B, 32'h0000_00FF);
    bus(1'b0, timer16_pkg::ADDR_CTRL_B, 32'h0);
    chk("ctrl_b rw", rd, 32'h0000_00DF);
    bus(1'b0, 6'h3C, 32'h0);
    chk("unmapped read", rd, 32'h0);
    cfg(8'h00, 8'h00);
    $display("test registers done");
  endtask
  task automatic t_pins();
    logic [7:0] v;
    bus(1'b1, timer16_pkg::ADDR_DIR, 32'h0);
    for (int ch = 0; ch < 3; ch++) begin
      for (int act = 0; act < 4; act++) begin
        v = 8'h00;
        v[6 - 2 * ch +: 2] = 2'(act);
        bus(1'b1, timer16_pkg::ADDR_CTRL_A, {24'h0, v});
        @(negedge clk_sys);
        chk("override", {29'h0, pinOverride}, 32'(act != 0) << ch);
        chk("enable off", {29'h0, pinOutEnable}, 32'h0);
        chk("pad", {31'h0, padLevel[ch]}, 32'(act != 0));
      end
    end
    bus(1'b1, timer16_pkg::ADDR_DIR, 32'h0000_0007);
    bus(1'b1, timer16_pkg::ADDR_CTRL_A, 32'h0000_00FC);
    @(negedge clk_sys);
    chk("enable on", {29'h0, pinOutEnable}, 32'h0000_0007);
    chk("pad follows", {29'h0, padLevel}, {29'h0, compareOut});
    $display("test pins done");
  endtask
  task automatic t_ctc();
    bus(1'b1, timer16_pkg::ADDR_COMPARE_A, 32'h0000_0005);
    bus(1'b1, timer16_pkg::ADDR_COMPARE_B, 32'h0000_0002);
    bus(1'b1, timer16_pkg::ADDR_COMPARE_C, 32'h0000_0003);
    cfg(8'h7C, 8'h09);
    bus(1'b0, timer16_pkg::ADDR_STATUS, 32'h0);
    measure(0, 60);
    chk("toggle count", 32'(tg >= 9 && tg <= 11), 32'h1);
    chk("set on match", {31'h0, compareOut[1]}, 32'h1);
    chk("set on match c", {31'h0, compareOut[2]}, 32'h1);
    bus(1'b1, timer16_pkg::ADDR_CTRL_A, 32'h0000_0078);
    repeat (20) @(negedge clk_sys);
    chk("clear on match", {31'h0, compareOut[2]}, 32'h0);
    bus(1'b0, timer16_pkg::ADDR_STATUS, 32'h0);
    chk("no overflow below max", {31'h0, rd[timer16_pkg::ST_OVF]}, 32'h0);
    chk("match a flag", {31'h0, rd[timer16_pkg::ST_MA]}, 32'h1);
    $display("test clear-on-match done");
  endtask
  task automatic t_fast();
    bus(1'b1, timer16_pkg::ADDR_COMPARE_B, 32'h0000_0040);
    bus(1'b1, timer16_pkg::ADDR_MASK, 32'h0000_0001);
    cfg(8'h21, 8'h09);
    repeat (300) @(posedge clk_sys);
    measure(1, 512);
    chk("fast duty", 32'(hi >= 126 && hi <= 134), 32'h1);
    chk("irq raised", {31'h0, irq}, 32'h1);
    bus(1'b0, timer16_pkg::ADDR_STATUS, 32'h0);
    chk("overflow at top", {31'h0, rd[timer16_pkg::ST_OVF]}, 32'h1);
    @(negedge clk_sys);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    bus(1'b1, timer16_pkg::ADDR_CTRL_A, 32'h0000_0031);
    repeat (300) @(posedge clk_sys);
    measure(1, 512);
    chk("fast inverted", 32'(hi >= 378 && hi <= 386), 32'h1);
    bus(1'b1, timer16_pkg::ADDR_MASK, 32'h0);
    bus(1'b1, timer16_pkg::ADDR_COMPARE_B, 32'h0000_00FF);
    bus(1'b1, timer16_pkg::ADDR_CTRL_A, 32'h0000_0021);
    repeat (600) @(posedge clk_sys);
    measure(1, 512);
    chk("compare at top", 32'(hi >= 510), 32'h1);
    chk("irq masked", {31'h0, irq}, 32'h0);
    // mode 15: top from compare a, action 01 toggles channel a
    cfg(8'h43, 8'h19);
    measure(0, 60);
    chk("pwm toggle a", 32'(tg >= 9 && tg <= 11), 32'h1);
    $display("test fast pwm done");
  endtask
  task automatic t_phase();
    bus(1'b1, timer16_pkg::ADDR_COMPARE_B, 32'h0000_0080);
    cfg(8'h21, 8'h01);
    repeat (600) @(posedge clk_sys);
    measure(1, 1020);
    chk("phase duty", 32'(hi >= 504 && hi <= 520), 32'h1);
    bus(1'b1, timer16_pkg::ADDR_CTRL_A, 32'h0000_0031);
    repeat (600) @(posedge clk_sys);
    measure(1, 1020);
    chk("phase inverted", 32'(hi >= 500 && hi <= 516), 32'h1);
    bus(1'b1, timer16_pkg::ADDR_COMPARE_B, 32'h0);
    bus(1'b1, timer16_pkg::ADDR_CTRL_A, 32'h0000_0021);
    repeat (1100) @(posedge clk_sys);
    measure(1, 1020);
    chk("bottom holds low", 32'(hi), 32'h0);
    $display("test phase correct done");
  endtask
  task automatic t_clock_capture();
    logic [31:0] c0;
    cfg(8'h00, 8'h02);
    bus(1'b0, timer16_pkg::ADDR_COUNT, 32'h0);
    c0 = rd;
    repeat (80) @(negedge clk_sys);
    bus(1'b0, timer16_pkg::ADDR_COUNT, 32'h0);
    chk("divide by 8", 32'((rd - c0) >= 9 && (rd - c0) <= 12), 32'h1);
    for (int e = 0; e < 2; e++) begin
      bus(1'b1, timer16_pkg::ADDR_CTRL_B, {24'h0, 1'(e), 1'(e), 6'h01});
      @(posedge clk_sys);
      capturePin <= ~1'(e);
      repeat (10) @(posedge clk_sys);
      bus(1'b0, timer16_pkg::ADDR_STATUS, 32'h0);
      capturePin <= 1'(e);
      repeat (12) @(posedge clk_sys);
      bus(1'b0, timer16_pkg::ADDR_STATUS, 32'h0);
      chk("capture edge", {31'h0, rd[timer16_pkg::ST_CAP]}, 32'h1);
    end
    $display("test clock and capture done");
  endtask
  // --------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_pins();
    t_ctc();
    t_fast();
    t_phase();
    t_clock_capture();
    end_sim();
  end
endmodule
